// >>> design/dci_decode.sv
// DDR4 command and address input decoder with power-state tracking
`timescale 1ns/1ps
module dci_decode #(
  parameter logic [1:0] ORG = dci_pkg::ORG_X4,
  parameter logic [1:0] STACK = dci_pkg::STK_1H,
  parameter bit DUAL_DIE = 1'b0
) (
  // System clock, reset and freeze
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Device reset pin, active low
  input wire logic reset_pin_n,
  // Memory clock and control pins
  input wire logic ck_t,
  input wire logic cke0,
  input wire logic cke1,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic odt0,
  input wire logic odt1,
  // Command and address pins
  input wire logic act_n,
  input wire logic [dci_pkg::ADDR_W-1:0] addr,
  input wire logic [dci_pkg::BG_W-1:0] bg,
  input wire logic [dci_pkg::BA_W-1:0] ba,
  input wire logic [dci_pkg::CID_W-1:0] cid,
  input wire logic par_in,
  // Parity enable from mode register 5 state
  input wire logic par_en,
  // Decoded command
  output dci_pkg::dci_cmd_e cmd,
  output logic cmd_vld,
  output logic die_sel,
  output logic [dci_pkg::CID_W-1:0] cmd_cid,
  output logic [dci_pkg::BG_W-1:0] cmd_bg,
  output logic [dci_pkg::BA_W-1:0] cmd_ba,
  output logic [dci_pkg::ADDR_W-1:0] cmd_addr,
  output logic auto_pre,
  output logic burst_chop,
  output logic par_err,
  // Power and buffer state
  output dci_pkg::dci_pwr_e pwr_state,
  output logic clk_on,
  output logic buf_cmd_en,
  output logic buf_odt_en,
  output logic any_open
);
  import dci_pkg::*;

  // Elaboration check on organisation and stack codes
  if (ORG > ORG_X16) begin : g_bad_org
    $error("ORG code not supported");
  end
  if (DUAL_DIE && STACK != STK_1H) begin : g_bad_ddp
    $error("Dual-die and chip-id stacking are exclusive");
  end

  localparam int PW = 3 + 1 + 1 + ADDR_W + BG_W + BA_W + CID_W + 1 + 4;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s;
  logic ck_s;
  logic [1:0] cke_s;
  logic [1:0] cs_n_s;
  logic [1:0] odt_s;
  logic act_n_s;
  logic [ADDR_W-1:0] a_s;
  logic [BG_W-1:0] bg_s;
  logic [BA_W-1:0] ba_s;
  logic [CID_W-1:0] cid_s;
  logic par_s;
  logic rstn_s;
  logic ck_d_r; // Previous sampled memory clock
  logic ck_rise; // Rising edge of memory clock
  logic [1:0] cke_prev_r; // Enable at the previous memory edge, or at the previous sample while in self refresh
  logic [NBANK-1:0] open_r; // Row-open state per bank
  dci_pwr_e ps_r;
  dci_pwr_e ps_nxt;
  dci_cmd_e dec;
  logic sel;
  logic bank_ok;
  logic [3:0] bidx;
  logic [ADDR_W-1:0] a_eff;
  logic [BG_W-1:0] bg_eff;
  logic int_rst;

  // Pin bundle into the shared synchroniser
  assign pin_raw = {ck_t, cke1, cke0, cs1_n, cs0_n, odt1, odt0,
                    act_n, addr, bg, ba, cid, par_in, reset_pin_n};
  dci_sync #(.W(PW)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(pin_raw),
    .pin_out(pin_s)
  );
  assign {ck_s, cke_s, cs_n_s, odt_s, act_n_s, a_s, bg_s, ba_s, cid_s,
          par_s, rstn_s} = pin_s;

  // internal reset from the device pin alone, active while pin low
  assign int_rst = ~rstn_s;

  // Organisation masking of bank group and A17
  function automatic logic [ADDR_W-1:0] mask_a(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] m;
    m = a;
    if (ORG != ORG_X4) begin
      m[A17_BIT] = 1'b0;
    end
    return m;
  endfunction : mask_a

  function automatic logic [BG_W-1:0] mask_bg(input logic [BG_W-1:0] g);
    logic [BG_W-1:0] m;
    m = g;
    if (ORG == ORG_X16) begin
      m[1] = 1'b0;
    end
    return m;
  endfunction : mask_bg

  assign a_eff = mask_a(a_s);
  assign bg_eff = mask_bg(bg_s);
  assign bidx = {bg_eff, ba_s};

  // Memory clock edge finder
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ck_d_r <= 1'b0;
    end else if (clk_en) begin
      ck_d_r <= ck_s;
    end
  end
  assign ck_rise = ck_s & ~ck_d_r;

  // select: die 1 by its own select when dual-die
  assign sel = ~cs_n_s[0] | (DUAL_DIE & ~cs_n_s[1]);

  // Command truth table decode
  always_comb begin
    dec = DCI_CMD_NONE;
    if (cke_prev_r[0] && !cke_s[0]) begin
      // enable falling: power-down or self refresh entry
      if (sel && act_n_s && a_s[16:14] == 3'b001) begin
        dec = DCI_CMD_SRE;
      end else begin
        dec = DCI_CMD_PDE;
      end
    end else if (!cke_prev_r[0] && cke_s[0]) begin
      dec = (ps_r == DCI_PS_SR) ? DCI_CMD_SRX : DCI_CMD_PDX;
    end else if (cke_prev_r[0] && cke_s[0] && sel) begin
      // decode only with enable high and select low
      if (!act_n_s) begin
        dec = DCI_CMD_ACT;
      end else begin
        unique case (a_s[16:14])
          3'b000: dec = DCI_CMD_MRS;
          3'b001: dec = DCI_CMD_REF;
          3'b010: dec = a_s[AP_BIT] ? DCI_CMD_PREA : DCI_CMD_PRE;
          3'b011: dec = DCI_CMD_RSV;
          3'b100: dec = DCI_CMD_WR;
          3'b101: dec = DCI_CMD_RD;
          3'b110: dec = DCI_CMD_ZQC;
          3'b111: dec = DCI_CMD_NOP;
        endcase
      end
    end
  end

  // Bank state tracking from decoded commands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      open_r <= '0;
    end else if (clk_en) begin
      if (int_rst) begin
        open_r <= '0;
      end else if (ck_rise && buf_cmd_en) begin
        unique case (dec)
          DCI_CMD_ACT: open_r[bidx] <= 1'b1;
          DCI_CMD_PRE: open_r[bidx] <= 1'b0;
          DCI_CMD_PREA: open_r <= '0;
          DCI_CMD_RD, DCI_CMD_WR: begin
            if (a_s[AP_BIT]) begin
              open_r[bidx] <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Power state next value
  always_comb begin
    ps_nxt = ps_r;
    unique case (ps_r)
      DCI_PS_IDLE: begin
        if (ck_rise && dec == DCI_CMD_SRE) begin
          ps_nxt = DCI_PS_SR;
        end else if (ck_rise && dec == DCI_CMD_PDE) begin
          ps_nxt = (|open_r) ? DCI_PS_APD : DCI_PS_PPD;
        end
      end
      DCI_PS_PPD, DCI_PS_APD: begin
        if (ck_rise && cke_s[0]) begin
          ps_nxt = DCI_PS_IDLE;
        end
      end
      DCI_PS_SR: begin
        // exit on enable level, no clock edge needed
        if (cke_s[0]) begin
          ps_nxt = DCI_PS_IDLE;
        end
      end
      default: ps_nxt = DCI_PS_IDLE;
    endcase
  end

  // Power state register and previous enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ps_r <= DCI_PS_IDLE;
      cke_prev_r <= 2'h3; // Enables idle high; zero would fake an exit
    end else if (clk_en) begin
      if (int_rst) begin
        ps_r <= DCI_PS_IDLE;
        cke_prev_r <= 2'h3;
      end else begin
        ps_r <= ps_nxt;
        if (ck_rise || ps_r == DCI_PS_SR) begin
          cke_prev_r <= cke_s;
        end
      end
    end
  end

  // Even parity over command and address pins
  function automatic logic calc_par(input logic an,
                                    input logic [BG_W-1:0] g,
                                    input logic [BA_W-1:0] b,
                                    input logic [16:0] a);
    return ^{an, g, b, a};
  endfunction : calc_par

  // registered outputs; self refresh exit needs no clock edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd <= DCI_CMD_NONE;
      cmd_vld <= 1'b0;
      die_sel <= 1'b0;
      cmd_cid <= '0;
      cmd_bg <= '0;
      cmd_ba <= '0;
      cmd_addr <= '0;
      auto_pre <= 1'b0;
      burst_chop <= 1'b0;
      par_err <= 1'b0;
    end else if (clk_en) begin
      cmd_vld <= 1'b0;
      par_err <= 1'b0;
      if (!int_rst && (ck_rise || dec == DCI_CMD_SRX) &&
          dec != DCI_CMD_NONE &&
          (buf_cmd_en || dec == DCI_CMD_PDX || dec == DCI_CMD_SRX)) begin
        cmd <= dec;
        cmd_vld <= 1'b1;
        // second die when chip select 0 is high, dual-die only
        die_sel <= DUAL_DIE & cs_n_s[0];
        // chip id only for x4/x8 stacks
        cmd_cid <= (ORG != ORG_X16 && STACK != STK_1H) ? cid_s : '0;
        // bank group and bank, also mode register select
        cmd_bg <= bg_eff;
        cmd_ba <= ba_s;
        // row, column or opcode from address
        cmd_addr <= a_eff;
        auto_pre <= (dec == DCI_CMD_RD || dec == DCI_CMD_WR) & a_s[AP_BIT];
        burst_chop <= (dec == DCI_CMD_RD || dec == DCI_CMD_WR) &
                      ~a_s[BC_BIT];
        par_err <= par_en & sel & (calc_par(act_n_s, bg_s, ba_s, a_s[16:0])
                             != par_s);
      end
    end
  end

  // buffer and clock gating from power state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_state <= DCI_PS_IDLE;
      clk_on <= 1'b0;
      buf_cmd_en <= 1'b0;
      buf_odt_en <= 1'b0;
      any_open <= 1'b0;
    end else if (clk_en) begin
      pwr_state <= ps_nxt;
      clk_on <= ~int_rst & (ps_nxt == DCI_PS_IDLE);
      buf_cmd_en <= ~int_rst & (ps_nxt == DCI_PS_IDLE);
      buf_odt_en <= ~int_rst & (ps_nxt != DCI_PS_SR);
      any_open <= |open_r;
    end
  end
endmodule : dci_decode

// >>> design/dci_pkg.sv
// Constants and types shared by the command and address input decoder
package dci_pkg;
  // Widths of the address, bank and chip-id fields
  localparam int ADDR_W = 18;
  localparam int BA_W = 2;
  localparam int BG_W = 2;
  localparam int CID_W = 3;
  localparam int NBANK = 16;
  // Address bit positions with extra meaning
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int A17_BIT = 17;
  // Pin synchroniser depth
  localparam int SYNC_DEPTH = 3;
  // Organisation codes
  localparam logic [1:0] ORG_X4 = 2'h0;
  localparam logic [1:0] ORG_X8 = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;
  // Stack height codes: planar, 2H, 4H, 8H
  localparam logic [1:0] STK_1H = 2'h0;
  localparam logic [1:0] STK_2H = 2'h1;
  localparam logic [1:0] STK_4H = 2'h2;
  localparam logic [1:0] STK_8H = 2'h3;
  // Decoded command codes
  typedef enum logic [3:0] {
    DCI_CMD_NONE = 4'h0,
    DCI_CMD_ACT = 4'h1,
    DCI_CMD_RD = 4'h2,
    DCI_CMD_WR = 4'h3,
    DCI_CMD_PRE = 4'h4,
    DCI_CMD_PREA = 4'h5,
    DCI_CMD_REF = 4'h6,
    DCI_CMD_MRS = 4'h7,
    DCI_CMD_SRE = 4'h8,
    DCI_CMD_SRX = 4'h9,
    DCI_CMD_PDE = 4'ha,
    DCI_CMD_PDX = 4'hb,
    DCI_CMD_ZQC = 4'hc,
    DCI_CMD_NOP = 4'hd,
    DCI_CMD_RSV = 4'he
  } dci_cmd_e;
  // Power states, one-hot
  typedef enum logic [3:0] {
    DCI_PS_IDLE = 4'h1,
    DCI_PS_PPD = 4'h2,
    DCI_PS_APD = 4'h4,
    DCI_PS_SR = 4'h8
  } dci_pwr_e;
endpackage : dci_pkg

// >>> design/dci_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dci_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Asynchronous input and filtered output
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  import dci_pkg::*;
  logic [W-1:0] s1_r; // First stage, read by s2 only
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // Shift chain; output moves only when stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pin_out <= '0;
    end else if (clk_en) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Per bit so a disagreeing bit does not hold back the rest
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          pin_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : dci_sync

// >>> tb/dci_monitor.sv
// Port-level assertions for the command decoder, bound to its top
`timescale 1ns/1ps
module dci_monitor #(
  parameter logic [1:0] ORG = dci_pkg::ORG_X4,
  parameter logic [1:0] STACK = dci_pkg::STK_1H,
  parameter bit DUAL_DIE = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Decoded command
  input dci_pkg::dci_cmd_e cmd,
  input wire logic cmd_vld,
  input wire logic die_sel,
  input wire logic [dci_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic auto_pre,
  input wire logic burst_chop,
  input wire logic par_err,
  // Power state
  input dci_pkg::dci_pwr_e pwr_state,
  input wire logic clk_on,
  input wire logic buf_cmd_en,
  input wire logic buf_odt_en,
  input wire logic any_open
);
  import dci_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Read or write being reported this cycle
  logic rdwr;
  assign rdwr = cmd_vld && (cmd == DCI_CMD_RD || cmd == DCI_CMD_WR);
  property p_vld_gap; cmd_vld |=> !cmd_vld [*5]; endproperty
  a_vld_gap: assert property (p_vld_gap)
    else $error("two commands closer than a memory clock");
  property p_ap; rdwr |-> auto_pre == cmd_addr[AP_BIT]; endproperty
  a_ap: assert property (p_ap) else $error("auto precharge wrong");
  property p_bc; rdwr |-> burst_chop != cmd_addr[BC_BIT]; endproperty
  a_bc: assert property (p_bc) else $error("burst chop wrong");
  property p_flags; cmd_vld && !rdwr |-> !auto_pre && !burst_chop;
  endproperty
  a_flags: assert property (p_flags) else $error("flags off rd/wr");
  property p_pre;
    cmd_vld && (cmd == DCI_CMD_PRE || cmd == DCI_CMD_PREA)
      |-> (cmd == DCI_CMD_PREA) == cmd_addr[AP_BIT];
  endproperty
  a_pre: assert property (p_pre) else $error("precharge scope wrong");
  property p_open; cmd_vld && cmd == DCI_CMD_ACT |=> any_open; endproperty
  a_open: assert property (p_open) else $error("row not open");
  property p_close; cmd_vld && cmd == DCI_CMD_PREA |-> ##[1:2] !any_open;
  endproperty
  a_close: assert property (p_close) else $error("rows stay open");
  property p_pd_buf;
    pwr_state != DCI_PS_IDLE ##1 pwr_state != DCI_PS_IDLE
      |-> !buf_cmd_en && !clk_on;
  endproperty
  a_pd_buf: assert property (p_pd_buf) else $error("buffers on");
  property p_sr_buf; pwr_state == DCI_PS_SR [*2] |-> !buf_odt_en;
  endproperty
  a_sr_buf: assert property (p_sr_buf) else $error("odt buffer on");
  property p_pde;
    cmd_vld && cmd == DCI_CMD_PDE
      |-> ##[0:2] pwr_state == (any_open ? DCI_PS_APD : DCI_PS_PPD);
  endproperty
  a_pde: assert property (p_pde) else $error("wrong power-down");
  property p_par; par_err |-> cmd_vld; endproperty
  a_par: assert property (p_par) else $error("stray parity error");
  property p_die; !die_sel || DUAL_DIE; endproperty
  a_die: assert property (p_die) else $error("second die picked");
  // Main scenarios reached
  c_srx: cover property (cmd_vld && cmd == DCI_CMD_SRX);
  c_apd: cover property (pwr_state == DCI_PS_APD);
  c_par: cover property (par_err);
endmodule : dci_monitor
bind dci_decode dci_monitor #(.ORG(ORG), .STACK(STACK), .DUAL_DIE(DUAL_DIE))
  u_mon (.sys_clk, .rst, .cmd, .cmd_vld, .die_sel, .cmd_addr, .auto_pre,
  .burst_chop, .par_err, .pwr_state, .clk_on, .buf_cmd_en, .buf_odt_en,
  .any_open);

// >>> tb/dci_ctl_model.sv
// Memory controller model: makes the memory clock and drives command pins
`timescale 1ns/1ps
module dci_ctl_model (
  // Memory clock and control
  output logic ck_t,
  output logic cke0,
  output logic cke1,
  output logic cs0_n,
  output logic cs1_n,
  output logic odt0,
  output logic odt1,
  // Command and address
  output logic act_n,
  output logic [dci_pkg::ADDR_W-1:0] addr,
  output logic [dci_pkg::BG_W-1:0] bg,
  output logic [dci_pkg::BA_W-1:0] ba,
  output logic [dci_pkg::CID_W-1:0] cid,
  output logic par_in
);
  import dci_pkg::*;
  bit ck_run = 1'b1; // Cleared only while the device self-refreshes
  bit busy = 1'b0; // A command owns the pins
  assign cke1 = cke0;
  // Single-die part: second select and termination stay idle
  initial begin
    {cs1_n, odt0, odt1} = 3'b100;
    {cke0, cs0_n, act_n, par_in} = 4'b1110;
    {addr, bg, ba, cid} = '0;
  end
  // Clock runs free, offset from the system clock, stops low when halted
  initial begin
    ck_t = 1'b0;
    #3;
    forever #40 ck_t = ck_run & ~ck_t;
  end
  // Pins change half a period before the sampling edge
  task automatic issue(input bit ke, input bit sel_n, input bit act,
      input logic [ADDR_W-1:0] a, input logic [1:0] g, input logic [1:0] b,
      input bit bad_par);
    busy = 1'b1;
    @(negedge ck_t);
    #1;
    // enable moves with a command here; t_sr also drives it directly while the clock is stopped
    cke0 = ke;
    cs0_n = sel_n;
    act_n = act;
    addr = a;
    bg = g;
    ba = b;
    // even parity over the command and address
    par_in = ^{act, g, b, a[16:0]} ^ bad_par;
    @(posedge ck_t);
    busy = 1'b0;
  endtask : issue
  // Deselect between commands; released pins show junk, not old values
  always @(negedge ck_t) begin
    #2;
    if (!busy) begin
      cs0_n = 1'b1;
      {act_n, addr, bg, ba, cid, par_in} = ~{act_n, addr, bg, ba, cid, par_in};
    end
  end
endmodule : dci_ctl_model

// >>> tb/testbench.sv
// Self-checking bench for the command and address decoder
`timescale 1ns/1ps
module testbench;
  import dci_pkg::*;
  logic sys_clk, rst, clk_en, reset_pin_n, par_en, par_in, act_n;
  logic ck_t, cke0, cke1, cs0_n, cs1_n, odt0, odt1, cmd_vld, die_sel;
  logic auto_pre, burst_chop, par_err, clk_on, buf_cmd_en, buf_odt_en;
  logic any_open;
  logic [ADDR_W-1:0] addr, cmd_addr;
  logic [BG_W-1:0] bg, cmd_bg;
  logic [BA_W-1:0] ba, cmd_ba;
  logic [CID_W-1:0] cid, cmd_cid;
  dci_cmd_e cmd;
  dci_pwr_e pwr_state;
  int failures = 0;
  int checks = 0;
  dci_decode DUT (.sys_clk, .rst, .clk_en, .reset_pin_n, .ck_t, .cke0,
    .cke1, .cs0_n, .cs1_n, .odt0, .odt1, .act_n, .addr, .bg, .ba, .cid,
    .par_in, .par_en, .cmd, .cmd_vld, .die_sel, .cmd_cid, .cmd_bg, .cmd_ba,
    .cmd_addr, .auto_pre, .burst_chop, .par_err, .pwr_state, .clk_on,
    .buf_cmd_en, .buf_odt_en, .any_open);
  dci_ctl_model ctl (.ck_t, .cke0, .cke1, .cs0_n, .cs1_n, .odt0, .odt1,
    .act_n, .addr, .bg, .ba, .cid, .par_in);
  // Closing report, reached from the end or from a stuck wait
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // Sample 1 ns after the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // Bounded wait for the decoded pulse; a missing one ends the run
  task automatic wait_vld(input bit want);
    bit got;
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++) begin
      tick(1);
      got = (cmd_vld === 1'b1);
    end
    chk("cmd_vld", got, want);
    if (want && !got) give_verdict();
  endtask : wait_vld
  task automatic t_act;
    ctl.issue(1, 0, 0, 18'h2c5a3, 2'h2, 2'h1, 0);
    wait_vld(1);
    chk("cmd", cmd, DCI_CMD_ACT);
    chk("row", cmd_addr, 18'h2c5a3);
    chk("bank", {cmd_bg, cmd_ba}, 4'h9);
    chk("die", die_sel, 0);
    chk("cid", cmd_cid, 0);
    tick(1);
    chk("open", any_open, 1);
  endtask : t_act
  // Reads and writes, every auto-precharge and chop combination
  task automatic t_rdwr;
    logic [17:0] a;
    for (int i = 0; i < 4; i++) begin
      a = 18'h00155 + 18'(i);
      a[16:14] = i[0] ? 3'h5 : 3'h4;
      a[AP_BIT] = i[1];
      a[BC_BIT] = i[0] ^ i[1];
      ctl.issue(1, 0, 1, a, 2'(i), 2'(i), 0);
      wait_vld(1);
      chk("cmd", cmd, i[0] ? DCI_CMD_RD : DCI_CMD_WR);
      chk("col", {cmd_bg, cmd_ba, cmd_addr[13:0]}, {2'(i), 2'(i),
        a[13:0]});
      chk("auto_pre", auto_pre, a[AP_BIT]);
      chk("chop", burst_chop, !a[BC_BIT]);
    end
  endtask : t_rdwr
  task automatic t_pre;
    ctl.issue(1, 0, 1, 18'h08000, 2'h3, 2'h2, 0);
    wait_vld(1);
    chk("cmd", cmd, DCI_CMD_PRE);
    chk("bank", {cmd_bg, cmd_ba}, 4'he);
    ctl.issue(1, 0, 1, 18'h08400, 2'h0, 2'h0, 0);
    wait_vld(1);
    chk("cmd", cmd, DCI_CMD_PREA);
    tick(2);
    chk("open", any_open, 0);
  endtask : t_pre
  // Power-down entry and exit; a read meanwhile is dropped
  task automatic t_pd(input bit open);
    ctl.issue(0, 1, 1, 18'h0, 2'h0, 2'h0, 0);
    wait_vld(1);
    chk("cmd", cmd, DCI_CMD_PDE);
    tick(3);
    chk("state", pwr_state, open ? DCI_PS_APD : DCI_PS_PPD);
    chk("bufs", {clk_on, buf_cmd_en, buf_odt_en}, 3'h1);
    ctl.issue(0, 0, 1, 18'h14000, 2'h0, 2'h0, 0);
    wait_vld(0);
    ctl.issue(1, 1, 1, 18'h0, 2'h0, 2'h0, 0);
    wait_vld(1);
    chk("cmd", cmd, DCI_CMD_PDX);
    tick(3);
    chk("bufs", {clk_on, buf_cmd_en, buf_odt_en}, 3'h7);
  endtask : t_pd
  // Mode register opcode, deselected read, then a read with bad parity
  task automatic t_mrs_sel;
    ctl.issue(1, 0, 1, 18'h00a55, 2'h1, 2'h3, 0);
    wait_vld(1);
    chk("cmd", cmd, DCI_CMD_MRS);
    chk("opcode", {cmd_bg, cmd_ba, cmd_addr[13:0]}, 18'h1ca55);
    ctl.issue(1, 1, 1, 18'h14000, 2'h0, 2'h0, 0);
    wait_vld(0);
    ctl.issue(1, 0, 1, 18'h14000, 2'h0, 2'h0, 1);
    wait_vld(1);
    chk("cmd", cmd, DCI_CMD_RD);
    chk("par_err", par_err, 1);
  endtask : t_mrs_sel
  // Self refresh, left by the enable alone while the clock is stopped
  task automatic t_sr;
    ctl.issue(0, 0, 1, 18'h04000, 2'h0, 2'h0, 0);
    wait_vld(1);
    chk("cmd", cmd, DCI_CMD_SRE);
    tick(3);
    chk("state", pwr_state, DCI_PS_SR);
    chk("bufs", {clk_on, buf_cmd_en, buf_odt_en}, 3'h0);
    ctl.ck_run = 1'b0;
    tick(20);
    ctl.cke0 = 1'b1;
    for (int i = 0; i < 20 && pwr_state !== DCI_PS_IDLE; i++) tick(1);
    tick(2);
    chk("state", pwr_state, DCI_PS_IDLE);
    chk("cmd", cmd, DCI_CMD_SRX);
    ctl.ck_run = 1'b1;
  endtask : t_sr
  // Device reset pin closes rows
  task automatic t_pin_rst;
    ctl.issue(1, 0, 0, 18'h00123, 2'h0, 2'h0, 0);
    wait_vld(1);
    reset_pin_n = 1'b0;
    tick(8);
    chk("open", any_open, 0);
    reset_pin_n = 1'b1;
    tick(8);
  endtask : t_pin_rst
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst, clk_en, par_en, reset_pin_n} = 4'he;
    tick(5);
    rst = 1'b0;
    reset_pin_n = 1'b1;
    tick(10);
    t_act();
    t_rdwr();
    t_pd(1);
    t_pre();
    t_pd(0);
    t_mrs_sel();
    t_sr();
    t_pin_rst();
    give_verdict();
  end
endmodule : testbench
